// File: core/rcr_top.sv
`timescale 1ns/100ps
module rcr_top import rcr_pkg::*; #(
   parameter int DEPTH = FIFO_DEPTH
) (
   input wire logic ref_clk, // 25 MHz clock
   input wire logic reset_n, // Async reset, active low
   input wire logic recovery_loop_freeze, // Freeze loop, async
   input wire logic recovery_override_enable, // Override enable, async
   input wire logic recovery_freq_detector_reset, // Frequency state reset, async
   input wire logic recovery_phase_detector_reset, // Phase state reset, async
   input wire logic receiver_analog_reset, // Receiver restart, async
   input wire logic rx_electrical_idle_flag, // Idle detected, async
   input wire logic [RATE_W-1:0] rx_rate_select, // Rate code, foreign clock
   input wire logic [DIV_W-1:0] static_rate_divider, // Divider for code 000
   input wire logic buffer_reset_on_rate_change, // Auto buffer reset enable
   input wire logic idle_reset_seq_enable, // Idle reset sequence enable
   input wire logic keep_state_on_idle, // Preserve loop over idle
   input wire logic frequency_clear_on_idle, // Clear frequency on idle
   input wire logic phase_clear_on_idle, // Clear phase on idle
   input wire logic linear_equalizer_select, // Linear mode when high, async
   input wire logic samp_valid, // Sampler pair valid
   input wire rcr_sample_t samp, // Edge and data samples
   output logic samp_ready, // Sampler pair accepted
   output logic out_valid, // Recovered word valid
   input wire logic out_ready, // Consumer takes word
   output rcr_word_t out_data, // Recovered bit and phase
   output logic [PI_W-1:0] edge_phase, // Edge interpolator code
   output logic [PI_W-1:0] data_phase, // Data interpolator code
   output logic [DIV_W-1:0] rate_divider, // Active divider
   output logic buffer_reset, // Buffer reset pulse
   output logic ref_lock, // Locked to reference
   output logic loop_frozen, // Loop held
   output logic idle_active, // Idle sequence running
   output logic linear_mode // Equalizer mode in use
);
   // Buffer level width
   localparam int LW = $clog2(DEPTH) + 1;
   // Two slots of slack cover the registered ready
   localparam logic [LW-1:0] ROOM_LIMIT = LW'(DEPTH - 2);

   // Whole block state, registered once per clock
   typedef struct packed {
      rcr_mode_t mode;
      logic signed [PHASE_W-1:0] phase_acc;
      logic signed [FREQ_W-1:0] freq;
      logic [PHASE_W-1:0] saved_phase;
      logic [FREQ_W-1:0] saved_freq;
      logic prev_data;
      logic have_prev;
      logic [RATE_W-1:0] rate;
      logic [RATE_W-1:0] rate_cand;
      logic [DIV_W-1:0] div;
      logic buf_reset;
      logic lock_ref;
      logic frozen;
      logic idle;
      logic lin_mode;
      logic samp_rdy;
      logic out_vld;
      rcr_word_t out_word;
      logic [PI_W-1:0] edge_ph;
      logic [PI_W-1:0] data_ph;
   } top_st_t;

   top_st_t st_q;
   top_st_t st_d;

   // Synchronised controls
   rcr_ctrl_t ctrl_raw;
   rcr_ctrl_t ctrl;
   logic [RATE_W-1:0] rate_sync;
   logic lin_sync;

   // Buffer handshake
   logic f_wr_valid;
   logic f_wr_ready;
   rcr_word_t f_wr_data;
   logic f_rd_valid;
   logic f_rd_ready;
   rcr_word_t f_rd_data;
   logic [LW-1:0] f_level;
   logic f_flush;

   // Codes 110 and 111 fall back to divide by one
   function automatic logic [DIV_W-1:0] rate_decode(input logic [RATE_W-1:0] code,
                                                    input logic [DIV_W-1:0] stat);
      logic [DIV_W-1:0] dv;
      dv = DIV_BY_1;
      case (code)
         RATE_STATIC: dv = stat;
         RATE_DIV1: dv = DIV_BY_1;
         RATE_DIV2: dv = DIV_BY_2;
         RATE_DIV4: dv = DIV_BY_4;
         RATE_DIV8: dv = DIV_BY_8;
         RATE_DIV16: dv = DIV_BY_16;
         default: dv = DIV_BY_1;
      endcase
      return dv;
   endfunction

   // Gather async controls for one synchroniser
   assign ctrl_raw.freeze = recovery_loop_freeze;
   assign ctrl_raw.override_en = recovery_override_enable;
   assign ctrl_raw.fd_reset = recovery_freq_detector_reset;
   assign ctrl_raw.pd_reset = recovery_phase_detector_reset;
   assign ctrl_raw.analog_reset = receiver_analog_reset;
   assign ctrl_raw.elec_idle = rx_electrical_idle_flag;

   // Async controls into the clock domain
   rcr_sync #(.WIDTH($bits(rcr_ctrl_t))) u_ctrl_sync (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .async_in(ctrl_raw),
      .sync_out(ctrl)
   );

   // Rate code from the second user clock, filtered below
   rcr_sync #(.WIDTH(RATE_W + 1)) u_rate_sync (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .async_in({rx_rate_select, linear_equalizer_select}),
      .sync_out({rate_sync, lin_sync})
   );

   // Recovered words wait here for the consumer
   rcr_fifo #(.WIDTH($bits(rcr_word_t)), .DEPTH(DEPTH)) u_fifo (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .flush(f_flush),
      .wr_valid(f_wr_valid),
      .wr_ready(f_wr_ready),
      .wr_data(f_wr_data),
      .rd_valid(f_rd_valid),
      .rd_ready(f_rd_ready),
      .rd_data(f_rd_data),
      .level(f_level)
   );

   // Loop helpers
   logic accept;
   logic transition;
   logic signed [PHASE_W-1:0] step;
   logic signed [FREQ_W-1:0] fstep;
   logic idle_seq;

   // Pairs are refused while the loop restarts
   assign accept = samp_valid && st_q.samp_rdy && f_wr_ready && (st_q.mode != ST_RESET);
   assign transition = st_q.have_prev && (st_q.prev_data != samp.data_bit);
   assign idle_seq = ctrl.elec_idle && idle_reset_seq_enable;
   assign f_wr_valid = accept;
   assign f_wr_data = '{data_bit: samp.data_bit, phase: st_q.phase_acc[PHASE_W-1 -: PI_W]};
   assign f_rd_ready = !st_q.out_vld || out_ready;
   assign f_flush = st_q.buf_reset || (st_q.mode == ST_RESET);

   always_comb begin
      st_d = st_q;
      step = '0;
      fstep = '0;
      st_d.buf_reset = 1'b0;
      // Status levels follow the synchronised controls
      st_d.frozen = ctrl.freeze;
      st_d.lock_ref = ctrl.freeze && !ctrl.override_en;
      st_d.lin_mode = lin_sync;

      // Rate code must hold two cycles before it is taken
      st_d.rate_cand = rate_sync;
      if (rate_sync == st_q.rate_cand && rate_sync != st_q.rate) begin
         st_d.rate = rate_sync;
         st_d.buf_reset = buffer_reset_on_rate_change;
      end
      st_d.div = rate_decode(st_q.rate, static_rate_divider);

      // Loop state machine
      unique case (st_q.mode)
         ST_RESET: begin
            // Loop restarts from zero phase and frequency
            st_d.phase_acc = PHASE_RST;
            st_d.freq = FREQ_RST;
            st_d.have_prev = 1'b0;
            if (!ctrl.analog_reset) begin
               st_d.mode = ST_TRACK;
            end
         end
         ST_TRACK: begin
            // Analog reset wins over idle and tracking
            if (ctrl.analog_reset) begin
               st_d.mode = ST_RESET;
            end else if (idle_seq) begin
               st_d.mode = ST_IDLE;
               // Snapshot for the restore on idle exit
               st_d.saved_phase = st_q.phase_acc;
               st_d.saved_freq = st_q.freq;
               if (frequency_clear_on_idle) begin
                  st_d.freq = FREQ_RST;
               end
               if (phase_clear_on_idle) begin
                  st_d.phase_acc = PHASE_RST;
               end
               st_d.have_prev = 1'b0;
            end else if (accept && !ctrl.freeze) begin
               // Bang-bang detector: edge equal to new bit means late
               if (transition) begin
                  if (samp.edge_bit == samp.data_bit) begin
                     step = -$signed(KP_STEP);
                     fstep = -$signed(KI_STEP);
                  end else begin
                     step = $signed(KP_STEP);
                     fstep = $signed(KI_STEP);
                  end
               end
               // Proportional step plus integrated frequency
               st_d.freq = st_q.freq + fstep;
               st_d.phase_acc = st_q.phase_acc + step + (st_q.freq >>> FREQ_SHIFT);
               st_d.prev_data = samp.data_bit;
               st_d.have_prev = 1'b1;
            end
         end
         ST_IDLE: begin
            // Loop held; restore overrides the clear options
            if (ctrl.analog_reset) begin
               st_d.mode = ST_RESET;
            end else if (!idle_seq) begin
               st_d.mode = ST_TRACK;
               if (keep_state_on_idle) begin
                  st_d.phase_acc = st_q.saved_phase;
                  st_d.freq = st_q.saved_freq;
               end
            end
         end
         default: begin
            st_d.mode = ST_RESET;
         end
      endcase

      // Detector resets act even while frozen
      if (ctrl.fd_reset) begin
         st_d.freq = FREQ_RST;
      end
      if (ctrl.pd_reset) begin
         st_d.phase_acc = PHASE_RST;
      end

      // Status and interpolator codes from the next state
      st_d.idle = (st_d.mode == ST_IDLE);
      st_d.samp_rdy = (f_level < ROOM_LIMIT) && (st_d.mode != ST_RESET);
      st_d.edge_ph = st_d.phase_acc[PHASE_W-1 -: PI_W];
      st_d.data_ph = st_d.phase_acc[PHASE_W-1 -: PI_W] + HALF_UI;

      // Output register stage after the buffer
      // Word held until the consumer takes it or a flush drops it
      if (f_flush) begin
         st_d.out_vld = 1'b0;
      end else if (f_rd_ready) begin
         st_d.out_vld = f_rd_valid;
         if (f_rd_valid) begin
            st_d.out_word = f_rd_data;
         end
      end
   end

   // Divider reads one until the static code is decoded
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         st_q <= '0;
         st_q.mode <= ST_RESET;
         st_q.rate <= RATE_RST;
         st_q.rate_cand <= RATE_RST;
         st_q.div <= DIV_RST;
      end else begin
         st_q <= st_d;
      end
   end

   // Outputs straight from the state register
   assign samp_ready = st_q.samp_rdy;
   assign out_valid = st_q.out_vld;
   assign out_data = st_q.out_word;
   assign edge_phase = st_q.edge_ph;
   assign data_phase = st_q.data_ph;
   assign rate_divider = st_q.div;
   assign buffer_reset = st_q.buf_reset;
   assign ref_lock = st_q.lock_ref;
   assign loop_frozen = st_q.frozen;
   assign idle_active = st_q.idle;
   assign linear_mode = st_q.lin_mode;
endmodule // rcr_top

// File: core/rcr_pkg.sv
package rcr_pkg;

   // Loop arithmetic
   localparam int PHASE_W = 12;
   localparam int PI_W = 7;
   localparam int FREQ_W = 12;
   localparam int DIV_W = 5;
   localparam int RATE_W = 3;
   localparam int FREQ_SHIFT = 4;
   localparam logic [PHASE_W-1:0] KP_STEP = 12'h010;
   localparam logic [FREQ_W-1:0] KI_STEP = 12'h001;
   localparam logic [PI_W-1:0] HALF_UI = 7'h40;

   // Reset values
   localparam logic [PHASE_W-1:0] PHASE_RST = 12'h000;
   localparam logic [FREQ_W-1:0] FREQ_RST = 12'h000;
   localparam logic [RATE_W-1:0] RATE_RST = 3'h0;
   localparam logic [DIV_W-1:0] DIV_RST = 5'h01;

   // Rate select codes and divider values
   localparam logic [RATE_W-1:0] RATE_STATIC = 3'h0;
   localparam logic [RATE_W-1:0] RATE_DIV1 = 3'h1;
   localparam logic [RATE_W-1:0] RATE_DIV2 = 3'h2;
   localparam logic [RATE_W-1:0] RATE_DIV4 = 3'h3;
   localparam logic [RATE_W-1:0] RATE_DIV8 = 3'h4;
   localparam logic [RATE_W-1:0] RATE_DIV16 = 3'h5;
   localparam logic [DIV_W-1:0] DIV_BY_1 = 5'h01;
   localparam logic [DIV_W-1:0] DIV_BY_2 = 5'h02;
   localparam logic [DIV_W-1:0] DIV_BY_4 = 5'h04;
   localparam logic [DIV_W-1:0] DIV_BY_8 = 5'h08;
   localparam logic [DIV_W-1:0] DIV_BY_16 = 5'h10;

   localparam int FIFO_DEPTH = 8;

   typedef struct packed {
      logic edge_bit;
      logic data_bit;
   } rcr_sample_t;

   typedef struct packed {
      logic data_bit;
      logic [PI_W-1:0] phase;
   } rcr_word_t;

   typedef struct packed {
      logic freeze;
      logic override_en;
      logic fd_reset;
      logic pd_reset;
      logic analog_reset;
      logic elec_idle;
   } rcr_ctrl_t;

   typedef enum logic [2:0] {
      ST_RESET = 3'b001,
      ST_TRACK = 3'b010,
      ST_IDLE = 3'b100
   } rcr_mode_t;

endpackage

// File: core/rcr_sync.sv
`timescale 1ns/100ps
module rcr_sync import rcr_pkg::*; #(
   parameter int WIDTH = 1
) (
   input wire logic ref_clk, // Clock
   input wire logic reset_n, // Async reset
   input wire logic [WIDTH-1:0] async_in, // Foreign input
   output logic [WIDTH-1:0] sync_out // Synchronised copy
);
   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] stable;
   } sync_st_t;

   sync_st_t st_q;
   sync_st_t st_d;

   always_comb begin
      st_d.meta = async_in;
      st_d.stable = st_q.meta;
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign sync_out = st_q.stable;
endmodule // rcr_sync

// File: core/rcr_fifo.sv
`timescale 1ns/100ps
module rcr_fifo import rcr_pkg::*; #(
   parameter int WIDTH = 8,
   parameter int DEPTH = FIFO_DEPTH
) (
   input wire logic ref_clk, // Clock
   input wire logic reset_n, // Async reset
   input wire logic flush, // Drop all contents
   input wire logic wr_valid, // Write request
   output logic wr_ready, // Room for a word
   input wire logic [WIDTH-1:0] wr_data, // Write word
   output logic rd_valid, // Word available
   input wire logic rd_ready, // Reader takes word
   output logic [WIDTH-1:0] rd_data, // Oldest word
   output logic [$clog2(DEPTH):0] level // Words held
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
   localparam logic [AW-1:0] LAST_IDX = AW'(DEPTH - 1);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
   } fifo_st_t;

   fifo_st_t st_q;
   fifo_st_t st_d;
   logic push;
   logic pop;

   assign wr_ready = (st_q.cnt != FULL_CNT);
   assign rd_valid = (st_q.cnt != '0);
   assign rd_data = st_q.mem[st_q.rp];
   assign level = st_q.cnt;
   assign push = wr_valid && wr_ready && !flush;
   assign pop = rd_valid && rd_ready && !flush;

   always_comb begin
      st_d = st_q;
      if (flush) begin
         st_d.wp = '0;
         st_d.rp = '0;
         st_d.cnt = '0;
      end else begin
         if (push) begin
            st_d.mem[st_q.wp] = wr_data;
            st_d.wp = (st_q.wp == LAST_IDX) ? '0 : st_q.wp + 1'b1;
         end
         if (pop) begin
            st_d.rp = (st_q.rp == LAST_IDX) ? '0 : st_q.rp + 1'b1;
         end
         if (push && !pop) begin
            st_d.cnt = st_q.cnt + 1'b1;
         end else if (pop && !push) begin
            st_d.cnt = st_q.cnt - 1'b1;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end
endmodule // rcr_fifo

// File: tb/rcr_chk.sv
`timescale 1ns/100ps
module rcr_chk import rcr_pkg::*; #(
   parameter int DEPTH = FIFO_DEPTH
) (
   input wire logic ref_clk, // Clock
   input wire logic reset_n, // Async reset
   input wire logic recovery_loop_freeze, // Freeze request
   input wire logic recovery_override_enable, // Override enable
   input wire logic receiver_analog_reset, // Receiver restart
   input wire logic [RATE_W-1:0] rx_rate_select, // Rate code
   input wire logic [DIV_W-1:0] static_rate_divider, // Divider for code 0
   input wire logic buffer_reset_on_rate_change, // Auto buffer reset
   input wire logic phase_clear_on_idle, // Phase clear option
   input wire logic linear_equalizer_select, // Linear mode request
   input wire logic samp_ready, // Pair accepted
   input wire logic out_valid, // Word valid
   input wire logic [PI_W-1:0] edge_phase, // Edge code
   input wire logic [PI_W-1:0] data_phase, // Data code
   input wire logic [DIV_W-1:0] rate_divider, // Active divider
   input wire logic buffer_reset, // Buffer reset pulse
   input wire logic ref_lock, // Reference lock
   input wire logic loop_frozen, // Loop held
   input wire logic idle_active, // Idle sequence
   input wire logic linear_mode // Mode in use
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   logic [3:0] stab_q;
   logic [RATE_W-1:0] rate_q;
   function automatic logic [DIV_W-1:0] dec(logic [RATE_W-1:0] c, logic [DIV_W-1:0] s);
      case (c)
         3'h0: return s;
         3'h2: return 5'h02;
         3'h3: return 5'h04;
         3'h4: return 5'h08;
         3'h5: return 5'h10;
         default: return 5'h01;
      endcase
   endfunction
   // Cycles the rate code has stood still
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         stab_q <= 4'h0;
         rate_q <= 3'h0;
      end else begin
         rate_q <= rx_rate_select;
         stab_q <= (rx_rate_select != rate_q) ? 4'h0 : stab_q + {3'h0, stab_q != 4'hF};
      end
   end
   sequence s_frozen;
      loop_frozen [*3];
   endsequence
   sequence s_lock_req;
      (recovery_loop_freeze && !recovery_override_enable) [*5];
   endsequence
   rate_decode_a: assert property (
      stab_q >= 4'hA |-> rate_divider == dec(rx_rate_select, static_rate_divider))
      else $error("rate divider does not match code");
   pulse_once_a: assert property (buffer_reset |=> !buffer_reset)
      else $error("buffer reset longer than one cycle");
   no_auto_reset_a: assert property (
      !buffer_reset_on_rate_change && !$past(buffer_reset_on_rate_change, 3) |-> !buffer_reset)
      else $error("buffer reset while disabled");
   freeze_hold_a: assert property (s_frozen |-> $stable(edge_phase))
      else $error("phase moved while frozen");
   lock_ref_a: assert property (s_lock_req |-> ref_lock && loop_frozen)
      else $error("no reference lock");
   sync_freeze_a: assert property ($rose(recovery_loop_freeze) |=> !loop_frozen)
      else $error("freeze acted without synchroniser");
   half_ui_a: assert property (
      samp_ready && $past(samp_ready) |-> data_phase == edge_phase + HALF_UI)
      else $error("data phase not half a unit from edge");
   linear_track_a: assert property (linear_equalizer_select [*4] |-> linear_mode)
      else $error("linear mode not taken");
   analog_reset_a: assert property (
      receiver_analog_reset [*6] |-> !samp_ready && !out_valid)
      else $error("stream alive in analog reset");
   phase_clear_a: assert property (
      (idle_active && phase_clear_on_idle) [*3] |-> edge_phase == 7'h00)
      else $error("phase not cleared on idle");
endmodule // rcr_chk

bind rcr_top rcr_chk #(.DEPTH(DEPTH)) u_chk (.*);

// File: tb/rcr_fabric.sv
`timescale 1ns/100ps
module rcr_fabric import rcr_pkg::*; (
   input wire logic ref_clk, // Clock
   input wire logic reset_n, // Async reset
   input wire logic src_en, // Offer pairs
   input wire logic dir, // Edge agrees with new bit
   input wire logic stall, // Consumer holds off
   output logic samp_valid, // Pair offered
   output rcr_sample_t samp, // Samples
   input wire logic samp_ready, // Pair taken
   input wire logic out_valid, // Word offered
   output logic out_ready, // Word taken
   output logic [15:0] n_sent, // Pairs accepted
   output logic [15:0] n_recv, // Words taken
   input wire rcr_word_t out_data, // Word contents
   output logic [15:0] n_bad // Words out of order
);
   logic bit_q;
   logic [6:0] prbs_q;
   logic [6:0] chk_q;
   logic new_bit;
   logic exp_bit;
   assign out_ready = !stall;
   // Seven-stage sequence keeps the traffic random for adaptation
   assign new_bit = prbs_q[6] ^ prbs_q[5];
   assign exp_bit = chk_q[6] ^ chk_q[5];
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         samp_valid <= 1'b0;
         samp <= '0;
         bit_q <= 1'b0;
         prbs_q <= 7'h7F;
         chk_q <= 7'h7F;
         n_sent <= 16'h0000;
         n_recv <= 16'h0000;
         n_bad <= 16'h0000;
      end else begin
         if (samp_valid && samp_ready) n_sent <= n_sent + 16'h0001;
         if (out_valid && out_ready) begin
            n_recv <= n_recv + 16'h0001;
            chk_q <= {chk_q[5:0], exp_bit};
            if (out_data.data_bit != exp_bit) n_bad <= n_bad + 16'h0001;
         end
         // Pair held until taken; idle lines keep toggling
         if (!samp_valid || samp_ready) begin
            samp_valid <= src_en;
            samp <= src_en ? {dir ? new_bit : bit_q, new_bit} : ~samp;
            bit_q <= src_en ? new_bit : bit_q;
            prbs_q <= src_en ? {prbs_q[5:0], new_bit} : prbs_q;
         end
      end
   end
endmodule // rcr_fabric

// File: tb/rcr_top_tb_top.sv
`timescale 1ns/100ps
module rcr_top_tb_top import rcr_pkg::*; ;
   logic ref_clk = 1'b0;
   logic reset_n = 1'b0;
   logic recovery_loop_freeze = 1'b0;
   logic recovery_override_enable = 1'b0;
   logic recovery_freq_detector_reset = 1'b0;
   logic recovery_phase_detector_reset = 1'b0;
   logic receiver_analog_reset = 1'b0;
   logic rx_electrical_idle_flag = 1'b0;
   logic [RATE_W-1:0] rx_rate_select = 3'h0;
   logic [DIV_W-1:0] static_rate_divider = 5'h04;
   logic buffer_reset_on_rate_change = 1'b1;
   logic idle_reset_seq_enable = 1'b0;
   logic keep_state_on_idle = 1'b0;
   logic frequency_clear_on_idle = 1'b0;
   logic phase_clear_on_idle = 1'b0;
   logic linear_equalizer_select = 1'b0;
   logic samp_valid, samp_ready, out_valid, out_ready;
   rcr_sample_t samp;
   rcr_word_t out_data;
   logic [PI_W-1:0] edge_phase, data_phase;
   logic [DIV_W-1:0] rate_divider;
   logic buffer_reset, ref_lock, loop_frozen, idle_active, linear_mode;
   logic src_en = 1'b0;
   logic dir = 1'b1;
   logic stall = 1'b0;
   logic [15:0] n_sent, n_recv, n_bad;
   int fail_count = 0;
   int cmp_count = 0;

   always #20 ref_clk = ~ref_clk;
   rcr_top #(.DEPTH(FIFO_DEPTH)) u_dut (.*);
   rcr_fabric u_fab (.*);

   task automatic tally_and_finish();
      if (fail_count == 0 && cmp_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic cyc(int n);
      repeat (n) @(negedge ref_clk);
   endtask
   function automatic logic pick(int s);
      case (s)
         0: return buffer_reset;
         1: return !samp_ready;
         2: return idle_active;
         default: return samp_ready;
      endcase
   endfunction
   task automatic wait_for(int s, string what);
      for (int i = 0; i < 40; i++) begin
         cyc(1);
         if (pick(s) === 1'b1) return;
      end
      fail_count++;
      $display("Error %s expected 1 seen timeout", what);
      tally_and_finish();
   endtask

   task automatic t_rate();
      logic [DIV_W-1:0] tbl [8] = '{5'h04, 5'h01, 5'h02, 5'h04, 5'h08, 5'h10, 5'h01, 5'h01};
      for (int k = 1; k <= 8; k++) begin
         @(posedge ref_clk) rx_rate_select <= 3'(k % 8);
         wait_for(0, "buffer_reset");
         cyc(3);
         chk("rate_divider", 16'(tbl[k % 8]), 16'(rate_divider));
      end
      @(posedge ref_clk) buffer_reset_on_rate_change <= 1'b0;
      @(posedge ref_clk) rx_rate_select <= 3'h5;
      for (int i = 0; i < 10; i++) begin
         cyc(1);
         chk("buffer_reset", 16'h0, 16'(buffer_reset));
      end
      chk("rate_divider", 16'h10, 16'(rate_divider));
   endtask
   task automatic t_track();
      logic [PI_W-1:0] p0;
      @(posedge ref_clk) src_en <= 1'b1;
      for (int i = 0; i < 2; i++) begin
         cyc(10);
         p0 = edge_phase;
         cyc(10);
         chk("edge_phase moving", 16'h1, 16'(p0 != edge_phase));
         chk("data_phase", 16'(7'(edge_phase + HALF_UI)), 16'(data_phase));
      end
   endtask
   task automatic t_freeze();
      logic [PI_W-1:0] p0;
      @(posedge ref_clk) recovery_loop_freeze <= 1'b1;
      cyc(6);
      p0 = edge_phase;
      chk("loop_frozen", 16'h1, 16'(loop_frozen));
      chk("ref_lock", 16'h1, 16'(ref_lock));
      cyc(20);
      chk("edge_phase held", 16'(p0), 16'(edge_phase));
      @(posedge ref_clk) recovery_override_enable <= 1'b1;
      cyc(6);
      chk("ref_lock", 16'h0, 16'(ref_lock));
      @(posedge ref_clk) recovery_loop_freeze <= 1'b0;
      recovery_override_enable <= 1'b0;
   endtask
   task automatic t_fifo();
      @(posedge ref_clk) stall <= 1'b1;
      wait_for(1, "samp_ready low");
      cyc(4);
      chk("out_valid", 16'h1, 16'(out_valid));
      @(posedge ref_clk) src_en <= 1'b0;
      stall <= 1'b0;
      cyc(20);
      chk("words", n_sent, n_recv);
      chk("data_bit order", 16'h0, n_bad);
      chk("out_valid", 16'h0, 16'(out_valid));
   endtask
   task automatic t_mode();
      @(posedge ref_clk) linear_equalizer_select <= 1'b1;
      @(posedge ref_clk) receiver_analog_reset <= 1'b1;
      cyc(8);
      chk("samp_ready", 16'h0, 16'(samp_ready));
      @(posedge ref_clk) receiver_analog_reset <= 1'b0;
      wait_for(3, "samp_ready");
      chk("linear_mode", 16'h1, 16'(linear_mode));
   endtask
   task automatic idle_round(input logic keep);
      logic [PI_W-1:0] p0;
      @(posedge ref_clk) src_en <= 1'b1;
      keep_state_on_idle <= keep;
      phase_clear_on_idle <= 1'b1;
      frequency_clear_on_idle <= 1'b1;
      idle_reset_seq_enable <= 1'b1;
      cyc(12);
      @(posedge ref_clk) src_en <= 1'b0;
      cyc(6);
      p0 = edge_phase;
      @(posedge ref_clk) rx_electrical_idle_flag <= 1'b1;
      recovery_loop_freeze <= 1'b1;
      wait_for(2, "idle_active");
      cyc(3);
      chk("edge_phase in idle", 16'h0, 16'(edge_phase));
      @(posedge ref_clk) rx_electrical_idle_flag <= 1'b0;
      recovery_loop_freeze <= 1'b0;
      cyc(8);
      chk("edge_phase after idle", 16'(keep ? p0 : 7'h00), 16'(edge_phase));
   endtask

   initial begin
      repeat (3) @(posedge ref_clk);
      chk("rate_divider in reset", 16'h01, 16'(rate_divider));
      reset_n <= 1'b1;
      wait_for(3, "samp_ready");
      t_rate();
      t_track();
      t_freeze();
      t_fifo();
      t_mode();
      idle_round(1'b0);
      idle_round(1'b1);
      tally_and_finish();
   end
endmodule // rcr_top_tb_top
